/* shared/relay_board_consts.svh */
`ifndef RELAY_BOARD_CONSTS_SVH
`define RELAY_BOARD_CONSTS_SVH

// Bus cycle slots, coded on the three mode lines
`define SLOT_READ_FIRST      3'h0
`define SLOT_READ_SECOND     3'h1
`define SLOT_READ_THIRD      3'h2
`define SLOT_BUS_RESET       3'h3
`define SLOT_ADDRESS_FIRST   3'h4
`define SLOT_ADDRESS_SECOND  3'h5
`define SLOT_ADDRESS_THIRD   3'h6
`define SLOT_BUS_WRITE       3'h7

// Write data fields
`define WR_STATE_BIT         0
`define WR_INDEX_LSB         1
`define WR_INDEX_MSB         3

// Relay vector and reset value
`define RELAY_MAX            8
`define RELAY_RESET          8'h00
`define VARIANT_RESET        3'h0

// Timing
`define CLK_HZ               25000000
`define LED_PULSE_MS         50
`define HOST_RESET_WAIT_MS   350

`endif

/* shared/relay_board_pkg.sv */
package relay_board_pkg;

    // Expansion bus pins as seen by the board
    typedef struct packed {
        logic       strobe;
        logic [2:0] mode;
        logic [7:0] data;
    } bus_pins_t;

    // Decoded relay write command
    typedef struct packed {
        logic [2:0] index;
        logic       state;
    } relay_cmd_t;

endpackage : relay_board_pkg

/* rtl/relay_board_bus_slave.sv */
`include "relay_board_consts.svh"

module relay_board_bus_slave #(
    parameter int         NUM_RELAYS       = 8,
    parameter logic [2:0] VARIANT_CODE     = `VARIANT_RESET,
    parameter int         LED_PULSE_CYCLES =
        `LED_PULSE_MS * (`CLK_HZ / 1000)
) (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_srst,
    input  wire relay_board_pkg::bus_pins_t i_bus,
    input  wire logic [2:0]                i_jumper_fitted,
    output logic [`RELAY_MAX-1:0]          o_relay_drive,
    output logic [`RELAY_MAX-1:0]          o_led,
    output logic                           o_selected
);

    localparam int CW = $clog2(LED_PULSE_CYCLES + 1);

    relay_board_pkg::bus_pins_t  bus_s1_reg;
    relay_board_pkg::bus_pins_t  bus_s2_reg;
    relay_board_pkg::bus_pins_t  bus_s3_reg;
    logic [2:0]                  jmp_s1_reg;
    logic [2:0]                  jmp_s2_reg;
    logic [3:0]                  nib_first_reg;
    logic [3:0]                  nib_second_reg;
    logic                        selected_reg;
    logic [`RELAY_MAX-1:0]       relay_reg;
    logic [CW-1:0]               led_cnt_reg;
    logic                        strobe_rise;
    logic                        addr_hit;
    relay_board_pkg::relay_cmd_t cmd;

    function automatic logic slot_is(input logic [2:0] mode,
                                     input logic [2:0] code);
        slot_is = (mode == code);
    endfunction : slot_is

    function automatic logic address_match(input logic [11:0] addr,
                                           input logic [2:0]  fitted);
        logic [11:0] own;
        own = {3'h0, ~fitted[2], 3'h0, ~fitted[1], VARIANT_CODE,
               ~fitted[0]};
        address_match = (addr == own);
    endfunction : address_match

    // Pins are asynchronous to the core clock
    always_ff @(posedge i_core_clk) begin
        bus_s1_reg <= i_bus;
        bus_s2_reg <= bus_s1_reg;
        bus_s3_reg <= bus_s2_reg;
        jmp_s1_reg <= i_jumper_fitted;
        jmp_s2_reg <= jmp_s1_reg;
    end

    // Data is assumed stable before the strobe rises
    assign strobe_rise = bus_s2_reg.strobe & ~bus_s3_reg.strobe;
    // Write field split
    // One driver for the whole struct
    assign cmd = {bus_s2_reg.data[`WR_INDEX_MSB:`WR_INDEX_LSB],
                  bus_s2_reg.data[`WR_STATE_BIT]};
    assign addr_hit = address_match({nib_first_reg, nib_second_reg,
                                     bus_s2_reg.data[3:0]}, jmp_s2_reg);

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            nib_first_reg  <= 4'h0;
            nib_second_reg <= 4'h0;
        end else if (strobe_rise) begin
            if (slot_is(bus_s2_reg.mode, `SLOT_ADDRESS_FIRST)) begin
                nib_first_reg <= bus_s2_reg.data[3:0];
            end
            if (slot_is(bus_s2_reg.mode, `SLOT_ADDRESS_SECOND)) begin
                nib_second_reg <= bus_s2_reg.data[3:0];
            end
        end
    end

    // Selection decided on the third address cycle
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            selected_reg <= 1'b0;
        end else if (strobe_rise) begin
            case (bus_s2_reg.mode)
                `SLOT_BUS_RESET: begin
                    selected_reg <= 1'b0;
                end
                `SLOT_ADDRESS_FIRST, `SLOT_ADDRESS_SECOND: begin
                    selected_reg <= 1'b0;
                end
                `SLOT_ADDRESS_THIRD: begin
                    selected_reg <= addr_hit;
                end
                default: begin
                    selected_reg <= selected_reg;
                end
            endcase
        end
    end

    // Relay state
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            relay_reg <= `RELAY_RESET;
        end else if (strobe_rise) begin
            if (slot_is(bus_s2_reg.mode, `SLOT_BUS_RESET)) begin
                relay_reg <= `RELAY_RESET;
            end else if (slot_is(bus_s2_reg.mode, `SLOT_BUS_WRITE)
                         && selected_reg
                         && (int'(cmd.index) < NUM_RELAYS)) begin
                relay_reg[cmd.index] <= cmd.state;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            led_cnt_reg <= '0;
        end else if (strobe_rise && addr_hit
                     && slot_is(bus_s2_reg.mode, `SLOT_ADDRESS_THIRD)) begin
            led_cnt_reg <= CW'(LED_PULSE_CYCLES);
        end else if (led_cnt_reg != '0) begin
            led_cnt_reg <= led_cnt_reg - CW'(1);
        end
    end

    assign o_relay_drive = relay_reg;
    assign o_selected    = selected_reg;

    generate
        if (NUM_RELAYS == `RELAY_MAX) begin : g_eight
            assign o_led = {{(`RELAY_MAX-1){1'b0}}, led_cnt_reg != '0};
        end else begin : g_six
            assign o_led = relay_reg;
        end
    endgenerate

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    logic write_ev;
    logic reset_ev;
    assign write_ev = strobe_rise
                    && slot_is(bus_s2_reg.mode, `SLOT_BUS_WRITE);
    assign reset_ev = strobe_rise
                    && slot_is(bus_s2_reg.mode, `SLOT_BUS_RESET);

    reset_clear_a: assert property (reset_ev |=>
        (o_relay_drive == '0) && !o_selected)
        else $error("bus reset slot did not clear board");
    select_hit_a: assert property (strobe_rise && addr_hit
        && slot_is(bus_s2_reg.mode, `SLOT_ADDRESS_THIRD) |=> o_selected)
        else $error("own address not selected");
    select_miss_a: assert property (strobe_rise && !addr_hit
        && slot_is(bus_s2_reg.mode, `SLOT_ADDRESS_THIRD) |=> !o_selected)
        else $error("foreign address selected board");
    new_address_a: assert property (strobe_rise
        && slot_is(bus_s2_reg.mode, `SLOT_ADDRESS_FIRST) |=> !o_selected)
        else $error("first address cycle kept selection");
    relay_write_a: assert property (write_ev && selected_reg
        && int'(cmd.index) < NUM_RELAYS
        |=> o_relay_drive[$past(cmd.index)] == $past(cmd.state))
        else $error("indexed relay not updated");
    others_hold_a: assert property (write_ev
        |=> ((o_relay_drive ^ $past(o_relay_drive))
             & ~(8'h01 << $past(cmd.index))) == 8'h00)
        else $error("write changed another relay");
    unselected_write_a: assert property (write_ev && !selected_reg
        |=> $stable(o_relay_drive))
        else $error("write while deselected changed relays");
    absent_relay_a: assert property (write_ev
        && int'(cmd.index) >= NUM_RELAYS |=> $stable(o_relay_drive))
        else $error("write to absent relay took effect");
    idle_hold_a: assert property (!strobe_rise [*2]
        |-> $stable(o_relay_drive))
        else $error("relays changed without a bus cycle");
    srst_clear_a: assert property (@(posedge i_core_clk)
        disable iff (1'b0) i_srst |=> (o_relay_drive == '0) && !o_selected)
        else $error("reset did not clear board");

    select_c: cover property (strobe_rise && addr_hit
        && slot_is(bus_s2_reg.mode, `SLOT_ADDRESS_THIRD));
    relay_on_c: cover property (write_ev && selected_reg && cmd.state);
    reset_slot_c: cover property (reset_ev && o_relay_drive != '0);
    abbreviated_c: cover property (strobe_rise && selected_reg
        && slot_is(bus_s2_reg.mode, `SLOT_ADDRESS_THIRD));

endmodule : relay_board_bus_slave

/* dv/relay_host_model.sv */
module relay_host_model #(
    parameter int WAIT_CYCLES = 20
) (
    input  wire logic                  i_core_clk,
    output relay_board_pkg::bus_pins_t o_bus
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_bus = '0;

    task automatic bus_op(input logic [2:0] m, input logic [7:0] d);
        @(posedge i_core_clk);
        o_bus.mode <= m;
        o_bus.data <= d;
        repeat (3) @(posedge i_core_clk);
        o_bus.strobe <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        o_bus.strobe <= 1'b0;
        // Idle data lines flip so no stale value helps
        @(posedge i_core_clk);
        o_bus.data <= ~d;
        repeat (2) @(posedge i_core_clk);
    endtask : bus_op

    // Reset slot, scaled wait
    // Scaled down from the real wait to keep runs short
    task automatic bus_reset;
        bus_op(3'h3, 8'h00);
        repeat (WAIT_CYCLES) @(posedge i_core_clk);
    endtask : bus_reset
endmodule : relay_host_model

/* dv/relay_board_bus_slave_bench.sv */
module relay_board_bus_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [2:0] V8 = 3'h5;
    localparam logic [2:0] V6 = 3'h2;

    logic                       i_core_clk = 1'b0;
    logic                       i_srst;
    logic [2:0]                 jumper;
    relay_board_pkg::bus_pins_t bus;
    logic [7:0]                 drv8, led8, drv6, led6, exp8;
    logic                       sel8, sel6;
    int                         errors = 0;
    int                         num_checks = 0;
    int                         cycles = 0;

    relay_host_model host_u (.i_core_clk(i_core_clk), .o_bus(bus));
    relay_board_bus_slave #(.NUM_RELAYS(8), .VARIANT_CODE(V8),
        .LED_PULSE_CYCLES(8)) dut_u (.i_core_clk(i_core_clk),
        .i_srst(i_srst), .i_bus(bus), .i_jumper_fitted(jumper),
        .o_relay_drive(drv8), .o_led(led8), .o_selected(sel8));
    relay_board_bus_slave #(.NUM_RELAYS(6), .VARIANT_CODE(V6),
        .LED_PULSE_CYCLES(8)) dut_six_u (.i_core_clk(i_core_clk),
        .i_srst(i_srst), .i_bus(bus), .i_jumper_fitted(jumper),
        .o_relay_drive(drv6), .o_led(led6), .o_selected(sel6));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic addr(input logic [3:0] a, b, c);
        host_u.bus_op(3'h4, {4'ha, a});
        host_u.bus_op(3'h5, {4'h0, b});
        host_u.bus_op(3'h6, {4'h0, c});
    endtask : addr

    task automatic sel(input logic [2:0] v, input logic [2:0] f);
        jumper <= f;
        addr({3'h0, ~f[2]}, {3'h0, ~f[1]}, {v, ~f[0]});
    endtask : sel

    task automatic wr(input logic [2:0] i, input logic s);
        host_u.bus_op(3'h7, {4'h0, i, s});
    endtask : wr

    task print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    always #20 i_core_clk = ~i_core_clk;

    // Hang guard, run needs about 1000 cycles
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        i_srst = 1'b1;
        jumper = 3'h7;
        repeat (10) @(posedge i_core_clk);
        check(drv8 | led8 | drv6 | led6, 8'h00);
        check({6'h0, sel8, sel6}, 8'h00);
        i_srst <= 1'b0;
        host_u.bus_reset();
        $display("test reset done");
        for (int f = 0; f < 8; f++) begin
            sel(V8, f[2:0]);
            check({6'h0, sel8, sel6}, 8'h02);
            check(led8, 8'h01);
            repeat (12) @(posedge i_core_clk);
            check(led8, 8'h00);
        end
        addr(4'h1, 4'h0, {V8, 1'b0});
        check({6'h0, sel8, sel6}, 8'h00);
        addr(4'h0, 4'h0, {V8, 1'b1});
        check({6'h0, sel8, sel6}, 8'h00);
        addr(4'h0, 4'h0, {V6, 1'b0});
        check({6'h0, sel8, sel6}, 8'h01);
        $display("test address done");
        sel(V8, 3'h7);
        exp8 = 8'h00;
        for (int i = 0; i < 8; i++) begin
            wr(i[2:0], 1'b1);
            exp8[i] = 1'b1;
            check(drv8, exp8);
        end
        for (int i = 0; i < 8; i += 2) begin
            wr(i[2:0], 1'b0);
        end
        check(drv8, 8'haa);
        $display("test eight done");
        sel(V6, 3'h7);
        wr(3'h7, 1'b1);
        wr(3'h6, 1'b1);
        wr(3'h5, 1'b1);
        check(drv6, 8'h20);
        check(led6, 8'h20);
        check(drv8, 8'haa);
        host_u.bus_op(3'h6, {4'h0, V8, 1'b0});
        check({6'h0, sel8, sel6}, 8'h02);
        check(led8, 8'h01);
        wr(3'h1, 1'b0);
        for (int m = 0; m < 3; m++) begin
            host_u.bus_op(m[2:0], 8'hff);
        end
        check(drv8, 8'ha8);
        host_u.bus_reset();
        check(drv8 | drv6 | led6, 8'h00);
        check({6'h0, sel8, sel6}, 8'h00);
        $display("test six done");
        sel(V8, 3'h7);
        wr(3'h0, 1'b1);
        check(drv8, 8'h01);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        @(posedge i_core_clk);
        check({drv8[7:1], sel8}, 8'h00);
        check(drv8, 8'h00);
        $display("test srst done");
        print_verdict();
    end
endmodule : relay_board_bus_slave_bench
